// ### rtu_handler.sv
// serial request handler: receiver, frame checks, execution, replies
//
// How it works
// - line runs at 115200 baud, eight data bits, no parity
// - read request: address, function, start, count, crc lo, crc hi
// - single write: address, function, register, data, crc lo, crc hi
// - multi write: address, function, start, count, byte count, data, crc
// - sixteen-bit count travels high byte then low byte
// - unicast requests answered only when address byte equals one
// - address zero is broadcast: execute, never reply
// - function code is always the second byte
// - read takes one or two registers, single write takes one
// - multi write takes exactly two consecutive registers
// - values travel big-endian, most significant register first
// - a real number spans two registers in that order
// - a bad request gets a reply whose second byte is the function code with bit 7 (0x80) set
// - unsupported function code gives exception code one
// - count not fitting or bad address gives exception code two
// - count out of range or byte count mismatch gives code three
// - crc mismatch drops the frame without reply
// - crc is sixteen bits, low byte sent first
// - serial framing error drops the frame without reply
// - requests arriving while busy are dropped without reply
// - read reply: address, function, byte count, values, crc
// - writes update registers then send a confirmation
`timescale 1ns/100ps
`default_nettype none
module rtu_handler
#(
    parameter int END_GAP_CYC = rtu_pkg::END_GAP_CYC,
    parameter int FAULT_GAP_CYC = rtu_pkg::FAULT_GAP_CYC
)
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // serial line
    input wire logic RXD,
    output logic TXD,
    output logic TXD_EN,
    // events
    output logic FRAME_DROP,
    output logic REG_WRITTEN
);

    // ************************************************************
    // state
    // ************************************************************
    localparam int GW = rtu_pkg::GAP_W;
    localparam logic [GW-1:0] END_GAP = GW'(END_GAP_CYC - 1);
    localparam logic [GW-1:0] FAULT_GAP = GW'(FAULT_GAP_CYC);

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic [3:0] rx_bitn;
        logic [7:0] rx_cnt;
        logic [7:0] rx_sh;
        logic in_frame;
        logic bad;
        logic [3:0] len;
        logic [15:0] rx_crc;
        logic [GW-1:0] gap;
        logic [12:0][7:0] buff;
        rtu_pkg::mode_e mode;
        rtu_pkg::kind_e kind;
        logic [7:0] code;
        logic [31:0] val;
        logic [3:0] tx_idx;
        logic [3:0] tx_bitn;
        logic [7:0] tx_cnt;
        logic [8:0] tx_sh;
        logic [15:0] tx_crc;
        logic txd;
        logic txen;
        logic drop;
        logic wrote;
    } state_s;

    state_s s_reg;
    state_s s_next;

    logic rx_ev;
    logic done_ev;
    logic busy;
    logic frame_ok;
    logic len_bad;
    logic bcast;
    logic [3:0] wr_idx;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] cnt;
    logic [7:0] bc;
    logic [7:0] exc;
    logic [3:0] n_pay;
    logic [7:0] tx_byte;
    logic mem_we;
    logic mem_re;
    logic [rtu_pkg::REG_AW-1:0] mem_waddr;
    logic [rtu_pkg::REG_AW-1:0] mem_raddr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;

    // ************************************************************
    // helpers
    // ************************************************************
    // one byte through the reflected crc, shared by receive and send
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ rtu_pkg::CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // exception code of a well formed frame, checked in protocol order
    function automatic logic [7:0] exc_of(input logic [7:0] fn,
                                          input logic [15:0] st,
                                          input logic [15:0] ct,
                                          input logic [7:0] bcnt);
        logic [16:0] last;
        last = {1'b0, st} + {1'b0, ct};
        exc_of = rtu_pkg::EX_NONE;
        if (fn != rtu_pkg::FN_READ && fn != rtu_pkg::FN_WR1
            && fn != rtu_pkg::FN_WRN)
            exc_of = rtu_pkg::EX_FUNC;
        else if (fn == rtu_pkg::FN_READ
                 && (ct == 16'h0000 || ct > rtu_pkg::RD_MAX))
            exc_of = rtu_pkg::EX_VALUE;
        else if (fn == rtu_pkg::FN_WRN
                 && (ct != rtu_pkg::WRN_CNT || bcnt != {ct[6:0], 1'b0}))
            exc_of = rtu_pkg::EX_VALUE;
        else if (fn == rtu_pkg::FN_WR1 ? {1'b0, st} >= rtu_pkg::NREGS
                                       : last > rtu_pkg::NREGS)
            exc_of = rtu_pkg::EX_ADDR;
    endfunction

    // ************************************************************
    // request fields
    // ************************************************************
    // fixed byte positions of every request layout
    assign func = s_reg.buff[1];
    assign start = {s_reg.buff[2], s_reg.buff[3]};
    assign cnt = {s_reg.buff[4], s_reg.buff[5]};
    assign bc = s_reg.buff[6];
    assign bcast = s_reg.buff[0] == rtu_pkg::BCAST_ADDR;
    assign exc = exc_of(func, start, cnt, bc);
    assign busy = s_reg.mode != rtu_pkg::M_IDLE;
    assign wr_idx = s_reg.in_frame ? s_reg.len : 4'h0;

    // a frame is ours only with a clean line, zero residue and our address or the broadcast address
    assign frame_ok = !s_reg.bad && s_reg.rx_crc == 16'h0000
        && s_reg.len >= rtu_pkg::MIN_LEN
        && (s_reg.buff[0] == rtu_pkg::OWN_ADDR || bcast);

    // length must fit the function; unknown functions skip this
    assign len_bad = (func == rtu_pkg::FN_WRN)
        ? ({4'h0, s_reg.len} != rtu_pkg::WRN_HDR + bc)
        : ((func == rtu_pkg::FN_READ || func == rtu_pkg::FN_WR1)
           && s_reg.len != rtu_pkg::FIX_LEN);

    // reply payload length before the crc
    assign n_pay = (s_reg.kind == rtu_pkg::K_READ)
        ? 4'h3 + {1'b0, cnt[1:0], 1'b0}
        : (s_reg.kind == rtu_pkg::K_ECHO) ? rtu_pkg::ECHO_LEN
                                          : rtu_pkg::EXC_LEN;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.drop = 1'b0;
        s_next.wrote = 1'b0;
        rx_ev = 1'b0;
        done_ev = 1'b0;
        tx_byte = 8'h00;
        mem_we = 1'b0;
        mem_re = 1'b0;
        mem_waddr = start[rtu_pkg::REG_AW-1:0];
        mem_raddr = start[rtu_pkg::REG_AW-1:0];
        mem_wdata = {s_reg.buff[4], s_reg.buff[5]};

        // pin synchroniser, second stage is the only reader of the first
        s_next.rx_s1 = RXD;
        s_next.rx_s2 = s_reg.rx_s1;

        // receiver: sample mid-bit, start, eight data, stop
        if (s_reg.rx_bitn == 4'h0)
        begin
            if (!s_reg.rx_s2)
            begin
                s_next.rx_bitn = rtu_pkg::UART_BITS;
                s_next.rx_cnt = rtu_pkg::HALF_CYC;
            end
        end
        else if (s_reg.rx_cnt != 8'h00)
            s_next.rx_cnt = s_reg.rx_cnt - 8'h01;
        else
        begin
            s_next.rx_cnt = rtu_pkg::BIT_CYC - 8'h01;
            s_next.rx_bitn = s_reg.rx_bitn - 4'h1;
            // a start bit gone high at mid-bit was a glitch
            if (s_reg.rx_bitn == rtu_pkg::UART_BITS && s_reg.rx_s2)
                s_next.rx_bitn = 4'h0;
            else if (s_reg.rx_bitn == 4'h1)
                rx_ev = 1'b1;
            else if (s_reg.rx_bitn != rtu_pkg::UART_BITS)
                s_next.rx_sh = {s_reg.rx_s2, s_reg.rx_sh[7:1]};
        end

        // frame assembly; the buffer is frozen while a request runs
        if (rx_ev)
        begin
            s_next.gap = '0;
            s_next.in_frame = 1'b1;
            s_next.len = s_reg.in_frame ? s_reg.len + 4'h1 : 4'h1;
            s_next.rx_crc = crc_byte(s_reg.in_frame ? s_reg.rx_crc
                                     : rtu_pkg::CRC_INIT,
                                     s_reg.rx_sh);
            s_next.bad = !s_reg.rx_s2 || busy
                || (s_reg.in_frame && (s_reg.bad
                    || s_reg.gap >= FAULT_GAP
                    || s_reg.len >= rtu_pkg::BUF_BYTES));
            if (!busy && wr_idx < rtu_pkg::BUF_BYTES)
                s_next.buff[wr_idx] = s_reg.rx_sh;
        end
        else if (s_reg.in_frame)
        begin
            s_next.gap = s_reg.gap + 1'b1;
            if (s_reg.gap == END_GAP)
            begin
                s_next.in_frame = 1'b0;
                done_ev = 1'b1;
            end
        end

        // a frame ending while busy has nowhere to go
        if (done_ev && busy)
            s_next.drop = 1'b1;

        // reply byte source: payload, then crc low, then crc high
        if (s_reg.tx_idx < n_pay)
        begin
            unique case (s_reg.tx_idx)
                4'h0: tx_byte = s_reg.buff[0];
                4'h1: tx_byte = (s_reg.kind == rtu_pkg::K_EXC)
                    ? s_reg.buff[1] | rtu_pkg::EXC_FLAG
                    : s_reg.buff[1];
                4'h2: tx_byte = (s_reg.kind == rtu_pkg::K_EXC) ? s_reg.code
                    : (s_reg.kind == rtu_pkg::K_READ)
                    ? {cnt[6:0], 1'b0} : s_reg.buff[2];
                4'h3: tx_byte = (s_reg.kind == rtu_pkg::K_READ)
                    ? s_reg.val[31:24] : s_reg.buff[3];
                4'h4: tx_byte = (s_reg.kind == rtu_pkg::K_READ)
                    ? s_reg.val[23:16] : s_reg.buff[4];
                4'h5: tx_byte = (s_reg.kind == rtu_pkg::K_READ)
                    ? s_reg.val[15:8] : s_reg.buff[5];
                default: tx_byte = s_reg.val[7:0];
            endcase
        end
        else if (s_reg.tx_idx == n_pay)
            tx_byte = s_reg.tx_crc[7:0];
        else
            tx_byte = s_reg.tx_crc[15:8];

        // request sequencer
        unique case (s_reg.mode)
            rtu_pkg::M_IDLE:
            begin
                s_next.tx_idx = 4'h0;
                s_next.tx_bitn = 4'h0;
                s_next.tx_crc = rtu_pkg::CRC_INIT;
                if (done_ev && frame_ok)
                    s_next.mode = rtu_pkg::M_CHECK;
                else if (done_ev)
                    s_next.drop = 1'b1;
            end
            rtu_pkg::M_CHECK:
            begin
                s_next.code = exc;
                if (exc == rtu_pkg::EX_NONE && len_bad)
                begin
                    s_next.mode = rtu_pkg::M_IDLE;
                    s_next.drop = 1'b1;
                end
                else if (exc != rtu_pkg::EX_NONE)
                begin
                    s_next.kind = rtu_pkg::K_EXC;
                    s_next.mode = bcast ? rtu_pkg::M_IDLE
                                        : rtu_pkg::M_TX;
                end
                else if (func == rtu_pkg::FN_READ)
                begin
                    s_next.kind = rtu_pkg::K_READ;
                    mem_re = !bcast;
                    s_next.mode = bcast ? rtu_pkg::M_IDLE
                                        : rtu_pkg::M_RD0;
                end
                else if (func == rtu_pkg::FN_WR1)
                begin
                    s_next.kind = rtu_pkg::K_ECHO;
                    mem_we = 1'b1;
                    s_next.wrote = 1'b1;
                    s_next.mode = bcast ? rtu_pkg::M_IDLE
                                        : rtu_pkg::M_TX;
                end
                else
                begin
                    // first, most significant register of the pair
                    s_next.kind = rtu_pkg::K_ECHO;
                    mem_we = 1'b1;
                    mem_wdata = {s_reg.buff[7], s_reg.buff[8]};
                    s_next.mode = rtu_pkg::M_WR1;
                end
            end
            rtu_pkg::M_RD0:
            begin
                s_next.val = {mem_rdata, 16'h0000};
                mem_re = 1'b1;
                mem_raddr = start[rtu_pkg::REG_AW-1:0] + 1'b1;
                s_next.mode = (cnt == rtu_pkg::RD_MAX) ? rtu_pkg::M_RD1
                                                       : rtu_pkg::M_TX;
            end
            rtu_pkg::M_RD1:
            begin
                s_next.val[15:0] = mem_rdata;
                s_next.mode = rtu_pkg::M_TX;
            end
            rtu_pkg::M_WR1:
            begin
                mem_we = 1'b1;
                mem_waddr = start[rtu_pkg::REG_AW-1:0] + 1'b1;
                mem_wdata = {s_reg.buff[9], s_reg.buff[10]};
                s_next.wrote = 1'b1;
                s_next.mode = bcast ? rtu_pkg::M_IDLE
                                    : rtu_pkg::M_TX;
            end
            rtu_pkg::M_TX:
            begin
                if (s_reg.tx_bitn == 4'h0)
                begin
                    if (s_reg.tx_idx == n_pay + 4'h2)
                        s_next.mode = rtu_pkg::M_IDLE;
                    else
                    begin
                        s_next.tx_sh = {1'b1, tx_byte};
                        s_next.tx_bitn = rtu_pkg::UART_BITS;
                        s_next.tx_cnt = rtu_pkg::BIT_CYC - 8'h01;
                        s_next.txd = 1'b0;
                        s_next.tx_idx = s_reg.tx_idx + 4'h1;
                        if (s_reg.tx_idx < n_pay)
                            s_next.tx_crc = crc_byte(s_reg.tx_crc,
                                                     tx_byte);
                    end
                end
                else if (s_reg.tx_cnt != 8'h00)
                    s_next.tx_cnt = s_reg.tx_cnt - 8'h01;
                else
                begin
                    // stop bit is the last shifted one, the line rests high
                    s_next.tx_cnt = rtu_pkg::BIT_CYC - 8'h01;
                    s_next.tx_bitn = s_reg.tx_bitn - 4'h1;
                    if (s_reg.tx_bitn != 4'h1)
                    begin
                        s_next.txd = s_reg.tx_sh[0];
                        s_next.tx_sh = {1'b0, s_reg.tx_sh[8:1]};
                    end
                end
            end
        endcase

        s_next.txen = s_next.mode == rtu_pkg::M_TX;
    end

    // ************************************************************
    // registers and store
    // ************************************************************
    // the line idles high so the synchroniser and sender reset high
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_reg <= '0;
            s_reg.txd <= rtu_pkg::LINE_IDLE;
            s_reg.rx_s1 <= rtu_pkg::LINE_IDLE;
            s_reg.rx_s2 <= rtu_pkg::LINE_IDLE;
        end
        else
            s_reg <= s_next;
    end

    hold_regs store
    (
        .clk(MCLK),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    assign TXD = s_reg.txd;
    assign TXD_EN = s_reg.txen;
    assign FRAME_DROP = s_reg.drop;
    assign REG_WRITTEN = s_reg.wrote;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    line_idle_a: assert property (!s_reg.txen |-> s_reg.txd)
        else $error("line not idle high outside a reply");
    start_bit_a: assert property ($fell(s_reg.txd) |-> ##216
        (!s_reg.txd && s_reg.tx_cnt == 8'h00))
        else $error("start bit length wrong");
    own_addr_a: assert property (s_reg.mode == rtu_pkg::M_TX
        |-> s_reg.buff[0] == rtu_pkg::OWN_ADDR)
        else $error("reply to a foreign address");
    bcast_quiet_a: assert property (s_reg.mode == rtu_pkg::M_CHECK
        && bcast |=> (s_reg.mode != rtu_pkg::M_TX) [*2])
        else $error("reply to a broadcast");
    crc_drop_a: assert property (done_ev
        && s_reg.rx_crc != 16'h0000 |=> s_reg.mode != rtu_pkg::M_CHECK)
        else $error("corrupt frame accepted");
    frame_err_a: assert property (rx_ev && !s_reg.rx_s2
        |=> s_reg.bad && s_reg.in_frame)
        else $error("framing error not marked");
    gap_fault_a: assert property (rx_ev && s_reg.in_frame
        && s_reg.gap >= FAULT_GAP |=> s_reg.bad)
        else $error("inner gap not marked");
    overflow_a: assert property (done_ev && busy
        |=> s_reg.drop && s_reg.mode != rtu_pkg::M_CHECK)
        else $error("frame taken while busy");
    bad_func_a: assert property (s_reg.mode == rtu_pkg::M_CHECK
        && exc == rtu_pkg::EX_FUNC && !bcast |=> s_reg.mode == rtu_pkg::M_TX
        && s_reg.kind == rtu_pkg::K_EXC && s_reg.code == rtu_pkg::EX_FUNC)
        else $error("unsupported function not refused");
    byte_count_a: assert property (s_reg.mode == rtu_pkg::M_CHECK
        && func == rtu_pkg::FN_WRN && cnt == rtu_pkg::WRN_CNT
        && bc != 8'h04 |=> s_reg.code == rtu_pkg::EX_VALUE)
        else $error("byte count mismatch not refused");
    exc_head_a: assert property (s_reg.mode == rtu_pkg::M_TX
        && s_reg.kind == rtu_pkg::K_EXC && s_reg.tx_bitn == 4'h0
        && s_reg.tx_idx == 4'h1 |=> s_reg.tx_sh[7:0] > rtu_pkg::EXC_FLAG)
        else $error("exception head byte not above 0x80");

endmodule
`default_nettype wire

// ### rtu_pkg.sv
// shared constants and types of the serial request handler
package rtu_pkg;

    // ************************************************************
    // serial line timing
    // ************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int BAUD = 115200;
    localparam int BIT_INT = CLK_HZ / BAUD;
    localparam logic [7:0] BIT_CYC = 8'(BIT_INT);
    localparam logic [7:0] HALF_CYC = 8'(BIT_INT / 2);
    localparam logic [3:0] UART_BITS = 4'hA;
    localparam int CHAR_BITS = 10;
    // silences in tenths of a character time
    localparam int END_TENTHS = 35;
    localparam int FAULT_TENTHS = 25;
    localparam int END_GAP_CYC = (END_TENTHS * CHAR_BITS * BIT_INT + 9) / 10;
    localparam int FAULT_GAP_CYC =
        (FAULT_TENTHS * CHAR_BITS * BIT_INT + 9) / 10;
    localparam int GAP_W = 14;
    localparam logic LINE_IDLE = 1'b1;

    // ************************************************************
    // frame contents
    // ************************************************************
    localparam logic [7:0] OWN_ADDR = 8'h01;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WR1 = 8'h06;
    localparam logic [7:0] FN_WRN = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EX_NONE = 8'h00;
    localparam logic [7:0] EX_FUNC = 8'h01;
    localparam logic [7:0] EX_ADDR = 8'h02;
    localparam logic [7:0] EX_VALUE = 8'h03;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] RD_MAX = 16'h0002;
    localparam logic [15:0] WRN_CNT = 16'h0002;
    localparam logic [3:0] FIX_LEN = 4'h8;
    localparam logic [7:0] WRN_HDR = 8'h09;
    localparam logic [3:0] MIN_LEN = 4'h4;
    localparam logic [3:0] BUF_BYTES = 4'hD;
    localparam logic [3:0] ECHO_LEN = 4'h6;
    localparam logic [3:0] EXC_LEN = 4'h3;

    // ************************************************************
    // holding register store
    // ************************************************************
    localparam int REG_AW = 4;
    localparam int NREG_WORDS = 16;
    localparam logic [16:0] NREGS = 17'h00010;

    typedef enum logic [2:0] {M_IDLE, M_CHECK, M_RD0, M_RD1, M_WR1, M_TX}
        mode_e;
    typedef enum logic [1:0] {K_READ, K_ECHO, K_EXC} kind_e;

endpackage

// ### hold_regs.sv
// holding register store with one write port and a registered read
`timescale 1ns/100ps
`default_nettype none
module hold_regs
(
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [rtu_pkg::REG_AW-1:0] waddr,
    input wire logic [15:0] wdata,
    // read port, data one cycle after the request
    input wire logic re,
    input wire logic [rtu_pkg::REG_AW-1:0] raddr,
    output logic [15:0] rdata
);

    logic [15:0] word_reg [rtu_pkg::NREG_WORDS];

    // no reset: contents belong to the instrument, not to the link
    always_ff @(posedge clk)
    begin
        if (we)
            word_reg[waddr] <= wdata;
        if (re)
            rdata <= word_reg[raddr];
    end

endmodule
`default_nettype wire

// ### host_model.sv
// serial master model: sends request bytes, collects reply bytes
`timescale 1ns/100ps
`default_nettype none
module host_model
(
    // clock and serial line
    input wire logic MCLK,
    output logic RXD,
    input wire logic TXD,
    input wire logic TXD_EN
);
    // line idles high between frames
    initial RXD = 1'b1;
    // one 8N1 character, lsb first, no parity
    task automatic put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            RXD <= f[i];
            repeat (rtu_pkg::BIT_INT) @(posedge MCLK);
        end
    endtask
    // collect a reply; an empty list means the device stayed silent
    task automatic get(output logic [7:0] q[$], input int lim);
        logic [7:0] b;
        q = {};
        for (int n = 0; n < lim && TXD_EN !== 1'b1; n++)
            @(posedge MCLK);
        while (TXD_EN === 1'b1)
        begin
            @(posedge MCLK);
            if (TXD === 1'b0)
            begin
                // sample at mid bit, far from either edge
                repeat (rtu_pkg::BIT_INT * 3 / 2) @(posedge MCLK);
                for (int i = 0; i < 8; i++)
                begin
                    b[i] = TXD;
                    repeat (rtu_pkg::BIT_INT) @(posedge MCLK);
                end
                q.push_back(b);
            end
        end
    endtask
endmodule
`default_nettype wire

// ### rtu_handler_tb.sv
// self-checking bench of the serial request handler
`timescale 1ns/100ps
`default_nettype none
module rtu_handler_tb;
    localparam int GAP = 2600;
    logic MCLK = 1'b0;
    logic RSTN;
    logic RXD;
    logic TXD;
    logic TXD_EN;
    logic FRAME_DROP;
    logic REG_WRITTEN;
    logic [7:0] drops = 8'h00;
    logic [7:0] writes = 8'h00;
    logic [7:0] r[$];
    logic [7:0] e[$];
    logic [3:0] a;
    logic [15:0] v;
    logic [31:0] w;
    int err_count = 0;
    int n_checks = 0;
    // short gaps keep the run brief; bytes go back to back
    rtu_handler #(.END_GAP_CYC(GAP), .FAULT_GAP_CYC(2500)) i_dut (
        .MCLK(MCLK), .RSTN(RSTN), .RXD(RXD), .TXD(TXD), .TXD_EN(TXD_EN),
        .FRAME_DROP(FRAME_DROP), .REG_WRITTEN(REG_WRITTEN));
    host_model i_host (.MCLK(MCLK), .RXD(RXD), .TXD(TXD), .TXD_EN(TXD_EN));
    // 25 MHz clock and event pulse counters
    initial forever #20 MCLK = ~MCLK;
    always @(posedge MCLK)
    begin
        if (FRAME_DROP === 1'b1) drops <= drops + 8'h01;
        if (REG_WRITTEN === 1'b1) writes <= writes + 8'h01;
    end
    // append reflected crc, low byte first
    function automatic void add_crc(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = rtu_pkg::CRC_INIT;
        foreach (q[i])
        begin
            c = c ^ 16'(q[i]);
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ rtu_pkg::CRC_POLY : c >> 1;
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endfunction
    // send a request, optionally spoiling its crc, then listen
    task automatic req(input logic [7:0] q[$], input logic [7:0] flip);
        add_crc(q);
        q[q.size() - 1] = q[q.size() - 1] ^ flip;
        foreach (q[i])
            i_host.put(q[i]);
        i_host.get(r, GAP + 200);
    endtask
    task automatic check_q(input string name);
        logic ok;
        n_checks++;
        ok = (r.size() == e.size());
        foreach (e[i])
            if (ok && r[i] !== e[i]) ok = 1'b0;
        if (!ok)
        begin
            err_count++;
            $display("wrong value %s expected %p seen %p", name, e, r);
        end
    endtask
    task automatic check_v(input string name, input logic [7:0] x, y);
        n_checks++;
        if (x !== y)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, x, y);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog: seven frames and their replies take about 165000 cycles
    initial
    begin
        repeat (180000) @(posedge MCLK);
        err_count++;
        print_verdict();
    end
    initial
    begin
        RSTN = 1'b0;
        void'($urandom(11229));
        repeat (3) @(posedge MCLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge MCLK);
        e = {};
        req('{8'h01, 8'h07}, 8'h01);
        check_q("bad crc reply");
        check_v("bad crc drop", 8'h01, drops);
        req('{8'h02, 8'h07}, 8'h00);
        check_q("foreign reply");
        check_v("foreign drop", 8'h02, drops);
        req('{8'h00, 8'h07}, 8'h00);
        check_q("broadcast reply");
        // broadcast pair write: base below 14 leaves room for a+2
        a = 4'($urandom % 14);
        w = $urandom;
        e = '{8'h00, 8'h10, 8'h00, {4'h0, a}, 8'h00, 8'h02, 8'h04,
            w[31:24], w[23:16], w[15:8], w[7:0]};
        req(e, 8'h00);
        e = {};
        check_q("broadcast write reply");
        check_v("broadcast write pulse", 8'h01, writes);
        $display("silent frames done");
        e = '{8'h01, 8'h87, 8'h01};
        add_crc(e);
        req('{8'h01, 8'h07}, 8'h00);
        check_q("exception reply");
        check_v("exception drop", 8'h02, drops);
        $display("exception done");
        v = 16'($urandom);
        e = '{8'h01, 8'h06, 8'h00, {4'h0, a + 4'h2}, v[15:8], v[7:0]};
        req(e, 8'h00);
        add_crc(e);
        check_q("write echo");
        check_v("write pulse", 8'h02, writes);
        $display("write done");
        // second register of the broadcast pair, then the single write
        e = '{8'h01, 8'h03, 8'h00, {4'h0, a + 4'h1}, 8'h00, 8'h02};
        req(e, 8'h00);
        e = '{8'h01, 8'h03, 8'h04, w[15:8], w[7:0], v[15:8], v[7:0]};
        add_crc(e);
        check_q("read reply");
        $display("read done");
        print_verdict();
    end
endmodule
`default_nettype wire
